// File: rtl/drt_pkg.sv
// Package with register map, field layout and types of the reloadable timer block.
package drt_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_PRESCALER = 12'h10c;
  localparam logic [11:0] IDX_SECONDARY = 12'h10d;
  localparam logic [11:0] IDX_PRIMARY = 12'h10e;
  localparam logic [11:0] IDX_PIN_SEL = 12'h181;
  localparam logic [11:0] IDX_CONTROL = 12'h100;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h101;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h102;
  localparam int unsigned PADDR_W = 14;

  // Control register fields.
  localparam int unsigned CTL_START = 0;
  localparam int unsigned CTL_COUNT_STAT = 1;
  localparam int unsigned CTL_FORCED_STOP = 2;
  localparam int unsigned CTL_WRC = 3;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_SRC_LO = 6;
  localparam int unsigned CTL_OS_START = 8;
  localparam int unsigned CTL_OS_STOP = 9;
  localparam int unsigned CTL_OS_STAT = 10;

  // Pin select register fields and bits that read back.
  localparam int unsigned PSEL_OUT_LOC = 0;
  localparam int unsigned PSEL_CLK_LO = 4;
  localparam logic [7:0] PSEL_RW_MASK = 8'h77;
  localparam logic [1:0] CLK_SEL_NONE = 2'h0;
  localparam logic [1:0] CLK_SEL_PIN_A = 2'h1;
  localparam logic [1:0] CLK_SEL_PIN_B = 2'h2;
  localparam logic [1:0] CLK_SEL_BAD = 2'h3;

  // Interrupt status bits.
  localparam int unsigned IRQ_UNDERFLOW = 0;
  localparam int unsigned IRQ_ONESHOT_END = 1;
  localparam int unsigned IRQ_W = 2;

  // Operating modes and count sources.
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WAVE = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_WAIT_OS = 2'h3;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_COMPANION = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // Reset and forced-stop values.
  localparam logic [7:0] COUNT_ALL_ONES = 8'hff;
  localparam logic [7:0] PIN_SEL_RESET = 8'h00;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_PRIMARY,
    PH_SECONDARY
  } drt_phase_type;

  // Pin-side outputs that travel together.
  typedef struct packed {
    logic port1_bit3;
    logic port3_bit1;
    logic companion_ext_clock;
  } drt_pins_type;

endpackage : drt_pkg

// File: rtl/drt_timer.sv
// Reloadable 8-bit timer with prescaler, primary and secondary periods and pin select.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps

// Notes on behaviour
// - 8-bit prescaler counts selected source or companion
// - Forced stop loads prescaler with FFh
// - Waveform mode alternates primary and secondary reload
// - Secondary write-only, used in waveform and wait
// - Secondary resets to FFh, forced stop too
// - Primary read returns live counter value
// - Primary read/write, sets one-shot or wait width
// - Forced stop loads primary with FFh
// - Bit 0 picks timer output pin location
// - Bits 5:4 route companion clock; 11 prohibited
// - Reserved bits write zero; bits 3,7 read zero
// - Forced stop clears start and status flags
module drt_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [drt_pkg::PADDR_W-1:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic companion_underflow,
  input wire logic port1_bit4_in,
  input wire logic port3_bit3_in,
  output drt_pkg::drt_pins_type pins,
  output logic irq
);
  import drt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic pready_ff, pslverr_ff, irq_ff;
  logic [31:0] prdata_ff;
  logic [7:0] pre_rld_ff, pre_cnt_ff, pri_rld_ff, sec_buf_ff, sec_rld_ff, cnt_ff;
  logic [7:0] pin_sel_ff;
  logic start_ff, wrc_ff;
  logic [1:0] mode_ff, src_ff;
  logic [2:0] div_ff;
  logic [IRQ_W-1:0] ist_ff, imask_ff;
  drt_phase_type phase_ff, nxt_phase;
  drt_pins_type pins_ff;
  logic [2:0] sync_ff [2];
  logic pin_level_ff [2];
  logic [11:0] idx;
  logic acc, wr, rd_setup, hit;
  logic wr_ctl, wr_pre, wr_pri, wr_sec, wr_psel, forced_stop, os_trig, os_stop;
  logic src_en, tick, pre_uf, cnt_step, cnt_uf, direct_wr, sec_enabled;
  logic cnt_load;
  logic [7:0] cnt_load_val;
  logic [31:0] rd_val;
  logic [IRQ_W-1:0] irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; a write takes effect at the edge where pready is sampled high.
  assign idx = paddr[PADDR_W-1:2];
  assign hit = (paddr[1:0] == 2'h0) && (idx == IDX_PRESCALER || idx == IDX_SECONDARY ||
               idx == IDX_PRIMARY || idx == IDX_PIN_SEL || idx == IDX_CONTROL ||
               idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
  assign acc = psel && penable && pready_ff;
  assign wr = acc && pwrite && hit;
  assign rd_setup = psel && penable && !pready_ff;
  assign wr_ctl = wr && idx == IDX_CONTROL;
  assign wr_pre = wr && idx == IDX_PRESCALER;
  assign wr_pri = wr && idx == IDX_PRIMARY;
  assign wr_sec = wr && idx == IDX_SECONDARY;
  assign wr_psel = wr && idx == IDX_PIN_SEL;
  assign forced_stop = wr_ctl && pwdata[CTL_FORCED_STOP];
  assign os_trig = wr_ctl && pwdata[CTL_OS_START];
  assign os_stop = wr_ctl && pwdata[CTL_OS_STOP];
  assign sec_enabled = (mode_ff == MODE_WAVE) || (mode_ff == MODE_WAIT_OS);
  // Writes go to the counter too while stopped or with write control clear.
  assign direct_wr = (phase_ff == PH_IDLE) || !wrc_ff;

  // Read mux; unassigned bits and write-only registers read as zero.
  always_comb begin
    rd_val = 32'h0;
    case (idx)
      IDX_PRESCALER: rd_val[7:0] = pre_cnt_ff;
      IDX_PRIMARY: rd_val[7:0] = cnt_ff;
      IDX_PIN_SEL: rd_val[7:0] = pin_sel_ff & PSEL_RW_MASK;
      IDX_CONTROL: begin
        rd_val[CTL_START] = start_ff;
        rd_val[CTL_COUNT_STAT] = phase_ff != PH_IDLE;
        rd_val[CTL_WRC] = wrc_ff;
        rd_val[CTL_MODE_LO +: 2] = mode_ff;
        rd_val[CTL_SRC_LO +: 2] = src_ff;
        rd_val[CTL_OS_STAT] = phase_ff != PH_IDLE && mode_ff[1];
      end
      IDX_IRQ_STATUS: rd_val[IRQ_W-1:0] = ist_ff;
      IDX_IRQ_MASK: rd_val[IRQ_W-1:0] = imask_ff;
      default: rd_val = 32'h0;
    endcase
  end

  // Answer one cycle into the access phase; unmapped addresses get pslverr.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= rd_setup;
      pslverr_ff <= rd_setup && !hit;
      if (rd_setup && !pwrite) begin
        prdata_ff <= hit ? rd_val : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; forced stop returns start to its reset value.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_ff <= 1'b0;
      wrc_ff <= 1'b0;
      mode_ff <= MODE_TIMER;
      src_ff <= SRC_F1;
    end else if (forced_stop) begin
      start_ff <= 1'b0;
    end else if (wr_ctl) begin
      start_ff <= pwdata[CTL_START];
      wrc_ff <= pwdata[CTL_WRC];
      mode_ff <= pwdata[CTL_MODE_LO +: 2];
      src_ff <= pwdata[CTL_SRC_LO +: 2];
    end
  end

  // Pin select; a write of the prohibited clock route keeps the old route.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sel_ff <= PIN_SEL_RESET;
    end else if (wr_psel) begin
      pin_sel_ff[PSEL_OUT_LOC] <= pwdata[PSEL_OUT_LOC];
      pin_sel_ff[2:1] <= pwdata[2:1];
      pin_sel_ff[6] <= pwdata[6];
      if (pwdata[PSEL_CLK_LO +: 2] != CLK_SEL_BAD) begin
        pin_sel_ff[PSEL_CLK_LO +: 2] <= pwdata[PSEL_CLK_LO +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal count sources f2 and f8 come from one free divider; f1 counts every cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  always_comb begin
    case (src_ff)
      SRC_F1: src_en = 1'b1;
      SRC_F2: src_en = div_ff[0];
      SRC_F8: src_en = div_ff == DIV8_LAST;
      SRC_COMPANION: src_en = companion_underflow;
      default: src_en = 1'b0;
    endcase
  end

  assign tick = src_en && phase_ff != PH_IDLE && !forced_stop;
  assign pre_uf = tick && pre_cnt_ff == 8'h0;
  assign cnt_step = pre_uf;
  assign cnt_uf = cnt_step && cnt_ff == 8'h0;

  // Prescaler reload value and counter.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_rld_ff <= COUNT_ALL_ONES;
      pre_cnt_ff <= COUNT_ALL_ONES;
    end else if (forced_stop) begin
      pre_rld_ff <= COUNT_ALL_ONES;
      pre_cnt_ff <= COUNT_ALL_ONES;
    end else begin
      if (wr_pre) begin
        pre_rld_ff <= pwdata[7:0];
      end
      if (wr_pre && direct_wr) begin
        pre_cnt_ff <= pwdata[7:0];
      end else if (pre_uf) begin
        pre_cnt_ff <= wr_pre ? pwdata[7:0] : pre_rld_ff;
      end else if (tick) begin
        pre_cnt_ff <= pre_cnt_ff - 8'h1;
      end
    end
  end

  // Primary and secondary reload values; the secondary is held until primary is written.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pri_rld_ff <= COUNT_ALL_ONES;
      sec_buf_ff <= COUNT_ALL_ONES;
      sec_rld_ff <= COUNT_ALL_ONES;
    end else if (forced_stop) begin
      pri_rld_ff <= COUNT_ALL_ONES;
      sec_buf_ff <= COUNT_ALL_ONES;
      sec_rld_ff <= COUNT_ALL_ONES;
    end else begin
      if (wr_sec && sec_enabled) begin
        sec_buf_ff <= pwdata[7:0];
      end
      if (wr_pri) begin
        pri_rld_ff <= pwdata[7:0];
        sec_rld_ff <= sec_buf_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing and the counter load it causes.
  always_comb begin
    nxt_phase = phase_ff;
    cnt_load = 1'b0;
    cnt_load_val = pri_rld_ff;
    case (phase_ff)
      PH_IDLE: begin
        if (start_ff && !mode_ff[1]) begin
          nxt_phase = PH_PRIMARY;
        end else if (start_ff && os_trig) begin
          nxt_phase = PH_PRIMARY;
          cnt_load = 1'b1;
        end
      end
      PH_PRIMARY: begin
        if (cnt_uf) begin
          cnt_load = 1'b1;
          if (sec_enabled) begin
            nxt_phase = PH_SECONDARY;
            cnt_load_val = sec_rld_ff;
          end else if (mode_ff == MODE_ONESHOT) begin
            nxt_phase = PH_IDLE;
          end
        end
      end
      PH_SECONDARY: begin
        if (cnt_uf) begin
          cnt_load = 1'b1;
          nxt_phase = (mode_ff == MODE_WAVE) ? PH_PRIMARY : PH_IDLE;
        end
      end
      default: nxt_phase = PH_IDLE;
    endcase
    if (!start_ff || (mode_ff[1] && os_stop)) begin
      nxt_phase = PH_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= PH_IDLE;
    end else if (forced_stop) begin
      phase_ff <= PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // The live counter; a direct primary write beats a reload.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= COUNT_ALL_ONES;
    end else if (forced_stop) begin
      cnt_ff <= COUNT_ALL_ONES;
    end else if (wr_pri && direct_wr) begin
      cnt_ff <= pwdata[7:0];
    end else if (cnt_load) begin
      cnt_ff <= cnt_load_val;
    end else if (cnt_step) begin
      cnt_ff <= cnt_ff - 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status is sticky, set wins over a write-one clear.
  assign irq_ev[IRQ_UNDERFLOW] = cnt_uf;
  assign irq_ev[IRQ_ONESHOT_END] = cnt_uf && mode_ff[1] && nxt_phase == PH_IDLE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ist_ff <= '0;
      imask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr && idx == IDX_IRQ_MASK) begin
        imask_ff <= pwdata[IRQ_W-1:0];
      end
      if (wr && idx == IDX_IRQ_STATUS) begin
        ist_ff <= (ist_ff & ~pwdata[IRQ_W-1:0]) | irq_ev;
      end else begin
        ist_ff <= ist_ff | irq_ev;
      end
      irq_ff <= |(ist_ff & imask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Companion clock pins pass three flops; a level counts once flops two and three agree.
  for (genvar i = 0; i < 2; i++) begin : g_pin_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync_ff[i] <= 3'h0;
        pin_level_ff[i] <= 1'b0;
      end else begin
        sync_ff[i] <= {sync_ff[i][1:0], (i == 0) ? port1_bit4_in : port3_bit3_in};
        if (sync_ff[i][1] == sync_ff[i][2]) begin
          pin_level_ff[i] <= sync_ff[i][2];
        end
      end
    end
  end

  // Pin outputs: timer level routed to one location, companion clock from the chosen pin.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_ff <= '0;
    end else begin
      pins_ff.port1_bit3 <= !pin_sel_ff[PSEL_OUT_LOC] && phase_ff == PH_SECONDARY;
      pins_ff.port3_bit1 <= pin_sel_ff[PSEL_OUT_LOC] && phase_ff == PH_SECONDARY;
      case (pin_sel_ff[PSEL_CLK_LO +: 2])
        CLK_SEL_PIN_A: pins_ff.companion_ext_clock <= pin_level_ff[0];
        CLK_SEL_PIN_B: pins_ff.companion_ext_clock <= pin_level_ff[1];
        CLK_SEL_NONE: pins_ff.companion_ext_clock <= 1'b0;
        default: pins_ff.companion_ext_clock <= 1'b0;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pins = pins_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence wave_primary_end_s;
    phase_ff == PH_PRIMARY && mode_ff == MODE_WAVE && cnt_uf && !wr_ctl && !wr_pri;
  endsequence

  sequence secondary_loaded_s;
    phase_ff == PH_SECONDARY && cnt_ff == $past(sec_rld_ff);
  endsequence

  pre_stop_a: assert property (forced_stop |=> pre_cnt_ff == COUNT_ALL_ONES
    && pre_rld_ff == COUNT_ALL_ONES) else $error("prescaler not set by forced stop");
  sec_stop_a: assert property (forced_stop |=> sec_rld_ff == COUNT_ALL_ONES)
    else $error("secondary not set by forced stop");
  pri_stop_a: assert property (forced_stop |=> cnt_ff == COUNT_ALL_ONES
    && pri_rld_ff == COUNT_ALL_ONES) else $error("primary not set by forced stop");
  stop_flags_a: assert property (forced_stop |=> !start_ff && phase_ff == PH_IDLE)
    else $error("flags survive forced stop");
  wave_alt_a: assert property (wave_primary_end_s |=> secondary_loaded_s)
    else $error("waveform did not switch to secondary");
  pre_reload_a: assert property (pre_uf && !wr_pre |=> pre_cnt_ff == $past(pre_rld_ff))
    else $error("prescaler did not reload");
  sec_ignore_a: assert property (wr_sec && !sec_enabled |=> $stable(sec_buf_ff))
    else $error("secondary written in disabled mode");
  pri_read_a: assert property (rd_setup && !pwrite && idx == IDX_PRIMARY
    |=> pready_ff && prdata_ff[7:0] == $past(cnt_ff)) else $error("primary read mismatch");
  clk_sel_a: assert property (pin_sel_ff[PSEL_CLK_LO +: 2] != CLK_SEL_BAD)
    else $error("prohibited clock route stored");
  rsv_read_a: assert property (rd_setup && !pwrite && idx == IDX_PIN_SEL
    |=> prdata_ff[3] == 1'b0 && prdata_ff[7] == 1'b0) else $error("unassigned bit reads one");
  out_route_a: assert property (!pin_sel_ff[PSEL_OUT_LOC] && !wr_psel
    |=> !pins_ff.port3_bit1) else $error("output on unselected pin");

endmodule : drt_timer

// File: testbench/tb_top.sv
// Self-checking bench for the reloadable timer, driven over APB.
`timescale 1ns/10ps
module tb_top;
  import drt_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic companion_underflow = 1'b0;
  logic port1_bit4_in = 1'b0;
  logic port3_bit3_in = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  drt_pins_type pins;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic last_err;
  int w;

  drt_timer u_drt_timer (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .companion_underflow(companion_underflow),
    .port1_bit4_in(port1_bit4_in), .port3_bit3_in(port3_bit3_in), .pins(pins), .irq(irq));

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares a seen value against the expected one and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request holds until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) begin
      n_errors++;
      $display("MISMATCH at %0t: bus answer never came", $time);
      complete_run();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares the word with the expected one.
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // Control word with write control always set, in every mode including timer.
  function automatic logic [31:0] ctl(input logic [1:0] mode, input logic [1:0] src,
                                      input logic st);
    return {24'h0, src, mode, 1'b1, 2'b00, st};
  endfunction : ctl

  // Picks one pin of the output struct.
  function automatic logic pinb(input int s);
    return (s == 0) ? pins.port1_bit3 : (s == 1) ? pins.port3_bit1 : pins.companion_ext_clock;
  endfunction : pinb

  // Waits, under a bound, until the chosen pin shows the wanted level.
  task automatic wait_pin(input int s, input logic lvl);
    int t;
    t = 0;
    @(negedge clk);
    while (pinb(s) !== lvl && t < 3000) begin
      @(negedge clk);
      t++;
    end
    check(32'(pinb(s)), 32'(lvl));
  endtask : wait_pin

  // Measures the length in cycles of the next high pulse on the chosen pin.
  task automatic measure(input int s);
    wait_pin(s, 1'b0);
    wait_pin(s, 1'b1);
    w = 0;
    while (pinb(s) === 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
  endtask : measure

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog that cuts a hung run short.
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end

  // Main sequence of tests.
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(IDX_PRESCALER, 32'hff);
    rd_chk(IDX_PRIMARY, 32'hff);
    rd_chk(IDX_SECONDARY, 32'h0);
    rd_chk(IDX_PIN_SEL, 32'h0);
    rd_chk(12'h0ff, 32'h0);
    check(32'(last_err), 32'h1);
    // Clock routing, a prohibited route code and the reserved and unassigned bits.
    apb(1'b1, IDX_PIN_SEL, 32'h11);
    port1_bit4_in <= 1'b1;
    wait_pin(2, 1'b1);
    apb(1'b1, IDX_PIN_SEL, 32'h31);
    rd_chk(IDX_PIN_SEL, 32'h11);
    apb(1'b1, IDX_PIN_SEL, 32'h99);
    rd_chk(IDX_PIN_SEL, 32'h11);
    apb(1'b1, IDX_PIN_SEL, 32'h20);
    @(posedge clk);
    port1_bit4_in <= 1'b0;
    port3_bit3_in <= 1'b1;
    wait_pin(2, 1'b1);
    apb(1'b1, IDX_PIN_SEL, 32'h00);
    wait_pin(2, 1'b0);
    // Read back of the counting registers while stopped.
    apb(1'b1, IDX_PRESCALER, 32'h00);
    rd_chk(IDX_PRESCALER, 32'h00);
    apb(1'b1, IDX_PRIMARY, 32'h03);
    rd_chk(IDX_PRIMARY, 32'h03);
    // Underflow interrupt: masked first, then unmasked, then cleared.
    apb(1'b1, IDX_CONTROL, ctl(MODE_TIMER, SRC_F1, 1'b1));
    repeat (20) @(negedge clk);
    check(32'(irq), 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h1);
    // Forced stop while counting returns counters and flags to reset values.
    apb(1'b1, IDX_CONTROL, 32'h4);
    rd_chk(IDX_PRESCALER, 32'hff);
    rd_chk(IDX_PRIMARY, 32'hff);
    apb(1'b0, IDX_CONTROL, 32'h0);
    check(rd & 32'h407, 32'h0);
    apb(1'b1, IDX_IRQ_STATUS, 32'h3);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    // A secondary write in timer mode is ignored, so the forced-stop value stays.
    apb(1'b1, IDX_SECONDARY, 32'h01);
    apb(1'b1, IDX_PRESCALER, 32'h00);
    apb(1'b1, IDX_PRIMARY, 32'h00);
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAVE, SRC_F1, 1'b1));
    measure(0);
    check(32'(w), 32'd256);
    // Waveform on the alternate pin with a prescaler of two steps.
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAVE, SRC_F1, 1'b0));
    apb(1'b1, IDX_PIN_SEL, 32'h01);
    apb(1'b1, IDX_PRESCALER, 32'h01);
    apb(1'b1, IDX_SECONDARY, 32'h02);
    apb(1'b1, IDX_PRIMARY, 32'h01);
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAVE, SRC_F1, 1'b1));
    measure(1);
    check(32'(w), 32'd6);
    check(32'(pins.port1_bit3), 32'h0);
    // A new secondary value waits for the primary write before it counts.
    apb(1'b1, IDX_SECONDARY, 32'h40);
    measure(1);
    check(32'(w), 32'd6);
    apb(1'b1, IDX_PRIMARY, 32'h01);
    wait_pin(1, 1'b1);
    measure(1);
    check(32'(w), 32'd130);
    wait_pin(1, 1'b1);
    apb(1'b0, IDX_PRIMARY, 32'h0);
    check(32'((rd >= 32'h38) && (rd <= 32'h40)), 32'h1);
    // Companion underflows as the prescaler's count source.
    apb(1'b1, IDX_CONTROL, 32'h4);
    apb(1'b1, IDX_PRESCALER, 32'h05);
    apb(1'b1, IDX_CONTROL, ctl(MODE_TIMER, SRC_COMPANION, 1'b1));
    repeat (2) begin
      @(posedge clk);
      companion_underflow <= 1'b1;
      @(posedge clk);
      companion_underflow <= 1'b0;
    end
    rd_chk(IDX_PRESCALER, 32'h03);
    // Wait one-shot: a primary wait, then a secondary pulse, then the timer stops.
    apb(1'b1, IDX_CONTROL, 32'h4);
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAIT_OS, SRC_F1, 1'b0));
    apb(1'b1, IDX_PRESCALER, 32'h00);
    apb(1'b1, IDX_SECONDARY, 32'h02);
    apb(1'b1, IDX_PRIMARY, 32'h01);
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAIT_OS, SRC_F1, 1'b1));
    apb(1'b1, IDX_CONTROL, ctl(MODE_WAIT_OS, SRC_F1, 1'b1) | (32'h1 << CTL_OS_START));
    measure(1);
    check(32'(w), 32'd3);
    rd_chk(IDX_IRQ_STATUS, 32'h3);
    complete_run();
  end
endmodule : tb_top
